//--- src/eew_pkg.sv
// Shared constants and types for the serial EEPROM bus slave write path.
package eew_pkg;

    // =====================================================================
    // Clock rate and timing.
    // =====================================================================
    localparam int unsigned CLK_SYS_HZ               = 25_000_000;
    localparam int unsigned PROGRAM_CYCLE_TIME_MS    = 10;
    localparam int unsigned PROGRAM_CYCLE_COUNT      = PROGRAM_CYCLE_TIME_MS * (CLK_SYS_HZ / 1000);
    localparam int unsigned POWERUP_TO_READ_DELAY_MS = 1;
    localparam int unsigned POWERUP_TO_WRITE_DELAY_MS = 1;

    // =====================================================================
    // Addressing and array layout.
    // =====================================================================
    localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
    localparam int unsigned MEM_ADDR_W    = 13;
    localparam int unsigned PAGE_ADDR_W   = 5;
    localparam int unsigned PAGE_BYTES    = 32;
    localparam logic [12:0] PROTECT_BASE  = 13'h1800;

    // =====================================================================
    // Bit counter positions within one nine-clock byte slot.
    // =====================================================================
    localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;

    // =====================================================================
    // State encodings.
    // =====================================================================
    typedef enum logic [2:0]
    {
        LK_IDLE,
        LK_DEVADDR,
        LK_ADDR_HI,
        LK_ADDR_LO,
        LK_WDATA,
        LK_RSTART,
        LK_RDATA,
        LK_IGNORE
    } eew_link_state_e;

    typedef enum logic [1:0]
    {
        PG_IDLE,
        PG_COPY,
        PG_WAIT
    } eew_prog_state_e;

endpackage

//--- src/eew_slave_write_path.sv
// Two-wire serial EEPROM slave: bus front end, page buffer and program timer.
//
// Functional notes
// - For ten milliseconds after a write stop, release the data line and refuse address.
// - Start is data falling while clock high; ignore the bus until one occurs.
// - Stop is data rising while clock high; every transaction ends with one.
// - Data is stable while clock is high; changes then mean start or stop.
// - Data line is only pulled low or released, never driven high.
// - Next three address bits must equal the three select strap pins.
// - Unconnected select straps count as logic zero.
// - Last address bit one means read, zero means write.
// - Receiver acknowledges each byte by holding data low in the ninth clock.
// - Acknowledge a matching address and every byte received while writing.
// - Reading: send eight bits, release, sample ack; continue on ack, else wait stop.
// - Byte write: address, two memory address bytes, one data byte, then stop.
// - Stop ending a write starts the programming cycle; bus refused meanwhile.
// - Page write accepts up to thirty-two data bytes in one cycle.
// - Each accepted data byte increments only the five low address bits.
// - More than thirty-two bytes wrap and overwrite buffered positions.
// - At the stop all buffered page bytes are programmed in one cycle.
// - Polling: address refused while programming, acknowledged once finished.
// - Write protect high protects the upper quarter; low or floating protects nothing.
// - Protected range 1800h to 1FFFh: addresses acknowledged, first data byte refused.
`timescale 1ns/100ps

module eew_slave_write_path
#(
    parameter int unsigned PROG_CYCLES = eew_pkg::PROGRAM_CYCLE_COUNT
)
(
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output wire logic o_sda,
    output wire logic o_sda_oe,
    input  wire logic i_select_strap_bit0,
    input  wire logic i_select_strap_bit1,
    input  wire logic i_select_strap_bit2,
    input  wire logic i_write_protect,
    output wire logic o_program_busy
);

    // =====================================================================
    // Elaboration checks and derived widths.
    // =====================================================================
    localparam int unsigned TIMER_W = $clog2(PROG_CYCLES + 1);
    if (PROG_CYCLES < 1)
    begin : g_bad_prog_cycles
        $error("PROG_CYCLES must be at least one");
    end

    // The array is written only by the program sequencer while the bus is
    // refused, and read by the link side only while it is not, so the two
    // clock domains never touch it in the same window.
    logic [7:0] mem_r [0:(1 << eew_pkg::MEM_ADDR_W) - 1];
    logic [7:0] page_buf_r [0:eew_pkg::PAGE_BYTES - 1];
    // =====================================================================
    // Declarations: data-line detectors, bus clock and system clock domains.
    // =====================================================================
    logic                          start_tgl_r;
    logic                          stop_tgl_r;
    eew_pkg::eew_link_state_e      state_r;
    eew_pkg::eew_link_state_e      state_nxt;
    logic                          start_seen_r;
    logic [3:0]                    bit_cnt_r;
    logic [3:0]                    bit_cnt_nxt;
    logic [7:0]                    shift_r;
    logic [7:0]                    shift_nxt;
    logic                          ack_r;
    logic                          ack_nxt;
    logic [4:0]                    addr_hi_r;
    logic [4:0]                    addr_hi_nxt;
    logic [12:0]                   addr_r;
    logic [12:0]                   addr_nxt;
    logic [7:0]                    tx_r;
    logic [7:0]                    tx_nxt;
    logic                          dirty_r;
    logic                          dirty_nxt;
    logic [eew_pkg::PAGE_BYTES-1:0] mask_r;
    logic [eew_pkg::PAGE_BYTES-1:0] mask_nxt;
    logic                          oe_r;
    logic [2:0]                    strap_meta_r;
    logic [2:0]                    strap_sync_r;
    logic                          wp_meta_r;
    logic                          wp_sync_r;
    logic                          busy_meta_r;
    logic                          busy_link_r;
    eew_pkg::eew_prog_state_e      prog_r;
    eew_pkg::eew_prog_state_e      prog_nxt;
    logic [4:0]                    copy_idx_r;
    logic [4:0]                    copy_idx_nxt;
    logic [TIMER_W-1:0]            timer_r;
    logic [TIMER_W-1:0]            timer_nxt;
    logic                          busy_r;
    logic                          stop_meta_r;
    logic                          stop_sync_r;
    logic                          stop_prev_r;
    logic                          dirty_meta_r;
    logic                          dirty_sync_r;

    // A falling data edge with the clock high marks a start.
    always_ff @(negedge i_sda or negedge i_reset_n)
    begin
        if (!i_reset_n)
            start_tgl_r <= 1'b0;
        else if (i_scl)
            start_tgl_r <= ~start_tgl_r;
    end

    // A rising data edge with the clock high marks a stop.
    always_ff @(posedge i_sda or negedge i_reset_n)
    begin
        if (!i_reset_n)
            stop_tgl_r <= 1'b0;
        else if (i_scl)
            stop_tgl_r <= ~stop_tgl_r;
    end

    // =====================================================================
    // Link domain decode.
    // =====================================================================
    // The start toggle is stable for a full clock-low phase before the
    // first rising edge, so it is compared directly on that edge.
    wire        start_new  = start_tgl_r ^ start_seen_r;
    wire [7:0]  rx_byte    = {shift_r[6:0], i_sda};
    wire        byte_end   = (bit_cnt_r == eew_pkg::LAST_DATA_BIT) & ~start_new;
    wire        ack_slot   = (bit_cnt_r == eew_pkg::ACK_SLOT) & ~start_new;
    wire [2:0]  strap_bits = strap_sync_r;
    wire        type_ok    = rx_byte[7:4] == eew_pkg::DEV_TYPE_CODE;
    wire        select_ok  = rx_byte[3:1] == strap_bits;
    wire        dev_match  = type_ok & select_ok & ~busy_link_r;
    wire        prot_hit   = wp_sync_r & (addr_r >= eew_pkg::PROTECT_BASE);
    wire        buf_we     = byte_end & (state_r == eew_pkg::LK_WDATA) & ~prot_hit;
    wire [4:0]  page_ptr   = addr_r[4:0];
    wire [4:0]  page_inc   = page_ptr + 5'h01;
    wire [12:0] addr_inc   = addr_r + 13'h0001;
    wire [7:0]  mem_rd     = mem_r[addr_r];
    wire [2:0]  tx_idx     = ~bit_cnt_r[2:0];
    wire        ack_drive  = (bit_cnt_r == eew_pkg::ACK_SLOT) & ack_r;
    wire        rd_phase   = (state_r == eew_pkg::LK_RDATA) & ~bit_cnt_r[3];
    wire        rd_drive   = rd_phase & ~tx_r[tx_idx];

    // Next-state logic for the byte engine, evaluated on each rising edge.
    always_comb
    begin
        state_nxt   = state_r;
        ack_nxt     = ack_r;
        addr_hi_nxt = addr_hi_r;
        addr_nxt    = addr_r;
        tx_nxt      = tx_r;
        dirty_nxt   = dirty_r;
        mask_nxt    = mask_r;
        shift_nxt   = rx_byte;
        bit_cnt_nxt = ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
        if (start_new)
        begin
            state_nxt   = eew_pkg::LK_DEVADDR;
            ack_nxt     = 1'b0;
            shift_nxt   = {7'h00, i_sda};
            bit_cnt_nxt = 4'h1;
        end
        else if (byte_end)
        begin
            unique case (state_r)
                eew_pkg::LK_DEVADDR:
                begin
                    ack_nxt = dev_match;
                    if (dev_match)
                    begin
                        // A new selection means the previous page was consumed.
                        dirty_nxt = 1'b0;
                        mask_nxt  = '0;
                        state_nxt = rx_byte[0] ? eew_pkg::LK_RSTART
                                               : eew_pkg::LK_ADDR_HI;
                    end
                    else
                        state_nxt = eew_pkg::LK_IGNORE;
                end
                eew_pkg::LK_ADDR_HI:
                begin
                    addr_hi_nxt = rx_byte[4:0];
                    ack_nxt     = 1'b1;
                    state_nxt   = eew_pkg::LK_ADDR_LO;
                end
                eew_pkg::LK_ADDR_LO:
                begin
                    addr_nxt  = {addr_hi_r, rx_byte};
                    ack_nxt   = 1'b1;
                    state_nxt = eew_pkg::LK_WDATA;
                end
                eew_pkg::LK_WDATA:
                begin
                    if (prot_hit)
                    begin
                        ack_nxt   = 1'b0;
                        state_nxt = eew_pkg::LK_IGNORE;
                    end
                    else
                    begin
                        ack_nxt            = 1'b1;
                        addr_nxt           = {addr_r[12:5], page_inc};
                        mask_nxt[page_ptr] = 1'b1;
                        dirty_nxt          = 1'b1;
                    end
                end
                default:
                    ack_nxt = 1'b0;
            endcase
        end
        else if (ack_slot)
        begin
            // Load the next read byte, or stop sending when the master declines.
            if ((state_r == eew_pkg::LK_RSTART) || ((state_r == eew_pkg::LK_RDATA) && !i_sda))
            begin
                tx_nxt    = mem_rd;
                addr_nxt  = addr_inc;
                state_nxt = eew_pkg::LK_RDATA;
            end
            else if (state_r == eew_pkg::LK_RDATA)
                state_nxt = eew_pkg::LK_IGNORE;
        end
    end

    // Byte engine state, sampled on the bus clock rising edge.
    always_ff @(posedge i_scl or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r      <= eew_pkg::LK_IDLE;
            start_seen_r <= 1'b0;
            bit_cnt_r    <= 4'h0;
            shift_r      <= 8'h00;
            ack_r        <= 1'b0;
            addr_hi_r    <= 5'h00;
            addr_r       <= 13'h0000;
            tx_r         <= 8'h00;
            dirty_r      <= 1'b0;
            mask_r       <= '0;
        end
        else
        begin
            state_r      <= state_nxt;
            start_seen_r <= start_tgl_r;
            bit_cnt_r    <= bit_cnt_nxt;
            shift_r      <= shift_nxt;
            ack_r        <= ack_nxt;
            addr_hi_r    <= addr_hi_nxt;
            addr_r       <= addr_nxt;
            tx_r         <= tx_nxt;
            dirty_r      <= dirty_nxt;
            mask_r       <= mask_nxt;
        end
    end

    // Page buffer; a wrapped position simply takes the newer byte.
    always_ff @(posedge i_scl)
    begin
        if (buf_we)
            page_buf_r[page_ptr] <= rx_byte;
    end

    // Straps, write protect and busy are resynchronised to the bus clock.
    always_ff @(posedge i_scl or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strap_meta_r <= 3'h0;
            strap_sync_r <= 3'h0;
            wp_meta_r    <= 1'b0;
            wp_sync_r    <= 1'b0;
            busy_meta_r  <= 1'b0;
            busy_link_r  <= 1'b0;
        end
        else
        begin
            strap_meta_r <= {i_select_strap_bit2, i_select_strap_bit1, i_select_strap_bit0};
            strap_sync_r <= strap_meta_r;
            wp_meta_r    <= i_write_protect;
            wp_sync_r    <= wp_meta_r;
            busy_meta_r  <= busy_r;
            busy_link_r  <= busy_meta_r;
        end
    end

    // The data pull-down changes only on the falling bus clock edge.
    always_ff @(negedge i_scl or negedge i_reset_n)
    begin
        if (!i_reset_n)
            oe_r <= 1'b0;
        else
            oe_r <= (ack_drive | rd_drive) & ~start_new;
    end

    // Open-drain pin: the level driven is always low.
    assign o_sda    = 1'b0;
    assign o_sda_oe = oe_r;

    // =====================================================================
    // System domain crossings.
    // =====================================================================
    // Stop toggle and page-dirty level pass two flip-flops each.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            stop_meta_r  <= 1'b0;
            stop_sync_r  <= 1'b0;
            stop_prev_r  <= 1'b0;
            dirty_meta_r <= 1'b0;
            dirty_sync_r <= 1'b0;
        end
        else
        begin
            stop_meta_r  <= stop_tgl_r;
            stop_sync_r  <= stop_meta_r;
            stop_prev_r  <= stop_sync_r;
            dirty_meta_r <= dirty_r;
            dirty_sync_r <= dirty_meta_r;
        end
    end

    // Stop event, commit decision and page copy addressing.
    wire        stop_evt     = stop_sync_r ^ stop_prev_r;
    wire        prog_idle    = prog_r == eew_pkg::PG_IDLE;
    wire        commit_start = prog_idle & stop_evt & dirty_sync_r;
    wire        copying      = prog_r == eew_pkg::PG_COPY;
    wire        copy_we      = copying & mask_r[copy_idx_r];
    wire        copy_last    = copy_idx_r == 5'h1F;
    wire [12:0] copy_addr    = {addr_r[12:5], copy_idx_r};

    // Copy the buffered page, then hold busy for the program time.
    always_comb
    begin
        prog_nxt     = prog_r;
        copy_idx_nxt = copy_idx_r;
        timer_nxt    = timer_r;
        unique case (prog_r)
            eew_pkg::PG_IDLE:
            begin
                if (commit_start)
                begin
                    prog_nxt     = eew_pkg::PG_COPY;
                    copy_idx_nxt = 5'h00;
                end
            end
            eew_pkg::PG_COPY:
            begin
                copy_idx_nxt = copy_idx_r + 5'h01;
                if (copy_last)
                begin
                    prog_nxt  = eew_pkg::PG_WAIT;
                    timer_nxt = TIMER_W'(PROG_CYCLES - 1);
                end
            end
            eew_pkg::PG_WAIT:
            begin
                if (timer_r == '0)
                    prog_nxt = eew_pkg::PG_IDLE;
                else
                    timer_nxt = timer_r - TIMER_W'(1);
            end
        endcase
    end

    // Sequencer registers; busy is a flop so the crossing sees no glitch.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prog_r     <= eew_pkg::PG_IDLE;
            copy_idx_r <= 5'h00;
            timer_r    <= '0;
            busy_r     <= 1'b0;
        end
        else
        begin
            prog_r     <= prog_nxt;
            copy_idx_r <= copy_idx_nxt;
            timer_r    <= timer_nxt;
            busy_r     <= prog_nxt != eew_pkg::PG_IDLE;
        end
    end

    // Every buffered page byte lands in the array within one busy period.
    always_ff @(posedge i_clk_sys)
    begin
        if (copy_we)
            mem_r[copy_addr] <= page_buf_r[copy_idx_r];
    end

    assign o_program_busy = busy_r;

endmodule

//--- tb/eew_chk_sva.sv
// Assertion checker for the serial EEPROM slave bus front end.
`timescale 1ns/100ps
module eew_chk
#(
    parameter int unsigned PROG_CYCLES = 20
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic i_select_strap_bit0,
    input wire logic i_select_strap_bit1,
    input wire logic i_select_strap_bit2,
    input wire logic i_write_protect,
    input wire logic o_program_busy
);
    localparam int BUSY_LO = PROG_CYCLES + 30;
    logic       scl_q;
    logic       sda_q;
    logic       frm_r;
    logic       first_r;
    logic [3:0] bit_r;
    logic [7:0] shf_r;
    logic [4:0] idle_r;
    logic [3:0] stop_r;
    // Bus conditions seen by the system clock, which is fast enough to sample the link.
    wire       start_ev = scl_q & i_scl & sda_q & ~i_sda;
    wire       stop_ev  = scl_q & i_scl & ~sda_q & i_sda;
    wire       rise_ev  = i_scl & ~scl_q;
    wire [6:0] me       = {4'hA, i_select_strap_bit2, i_select_strap_bit1, i_select_strap_bit0};

    // Track framing, bit position, the address byte and quiet times.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            frm_r   <= 1'b0;
            first_r <= 1'b0;
            bit_r   <= 4'h0;
            shf_r   <= 8'h00;
            idle_r  <= 5'h1F;
            stop_r  <= 4'hF;
        end
        else
        begin
            scl_q   <= i_scl;
            sda_q   <= i_sda;
            frm_r   <= start_ev | (frm_r & ~stop_ev);
            first_r <= start_ev | (first_r & ~(rise_ev & (bit_r == 4'h8)));
            bit_r   <= start_ev ? 4'h0 : !rise_ev ? bit_r : (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
            shf_r   <= rise_ev ? {shf_r[6:0], i_sda} : shf_r;
            idle_r  <= o_program_busy ? 5'h00 : (idle_r == 5'h1F) ? idle_r : idle_r + 5'h01;
            stop_r  <= stop_ev ? 4'h0 : (stop_r == 4'hF) ? stop_r : stop_r + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // The busy flag holds for a good stretch once raised.
    sequence s_busy_run;
        o_program_busy [*8];
    endsequence

    a_drive_low_only: assert property (o_sda_oe |-> o_sda == 1'b0)
        else $error("data line driven high");
    a_edge_on_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data drive changed while clock high");
    a_stable_scl_high: assert property (i_scl && scl_q |-> $stable(o_sda_oe))
        else $error("data drive moved during clock high");
    a_quiet_busy: assert property (o_program_busy |-> !o_sda_oe)
        else $error("data line pulled while programming");
    a_busy_after_stop: assert property ($rose(o_program_busy) |-> stop_r < 4'h9)
        else $error("programming began without a stop");
    a_busy_hold: assert property ($rose(o_program_busy) |-> s_busy_run)
        else $error("programming ended too soon");
    a_busy_span: assert property ($rose(o_program_busy) |->
        ##BUSY_LO o_program_busy ##[1:40] !o_program_busy)
        else $error("programming time wrong");
    a_no_ack_unframed: assert property ($rose(o_sda_oe) |-> frm_r)
        else $error("drive outside a frame");
    a_addr_quiet: assert property (first_r && bit_r < 4'h8 |-> !o_sda_oe)
        else $error("drive during address bits");
    a_nack_other: assert property (first_r && bit_r == 4'h8
        && shf_r[7:1] != me |-> !o_sda_oe)
        else $error("foreign address acknowledged");
    a_ack_match: assert property (first_r && bit_r == 4'h8 && !i_scl
        && !scl_q && shf_r[7:1] == me && idle_r == 5'h1F |-> o_sda_oe)
        else $error("own address not acknowledged");
endmodule

bind eew_slave_write_path eew_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (.i_clk_sys, .i_reset_n,
    .i_scl, .i_sda, .o_sda, .o_sda_oe, .i_select_strap_bit0, .i_select_strap_bit1,
    .i_select_strap_bit2, .i_write_protect, .o_program_busy);

//--- tb/eew_bus_master.sv
// Bus master model that clocks the two-wire link and shifts bytes.
`timescale 1ns/100ps
module eew_bus_master
(
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // Clock stands high and data is released between frames.
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Start or repeated start: data falls while the clock is high.
    task automatic bus_start();
        o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
        #40;
    endtask

    // Stop, then leave the bus free before the next start.
    task automatic bus_stop();
        o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        #400;
    endtask

    // One clock pulse; data changes only while the clock is low.
    task automatic bus_bit(input logic b, output logic s);
        o_sda = b;
        #40 o_scl = 1'b1;
        #40 s = i_sda;
        #40 o_scl = 1'b0;
        #40;
    endtask

    // Send a byte most significant bit first and take the answer.
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bus_bit(d[i], s);
        bus_bit(1'b1, s);
        ack = ~s;
    endtask

    // Take a byte, then acknowledge only when more is wanted.
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bus_bit(1'b1, s);
            d[i] = s;
        end
        bus_bit(~more, s);
    endtask
endmodule

//--- tb/test_serial_eeprom_slave_write_path.sv
// Self-checking testbench for the serial EEPROM slave write path.
`timescale 1ns/100ps
module test_serial_eeprom_slave_write_path;
    logic       i_clk_sys = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       i_write_protect = 1'b0;
    logic       i_select_strap_bit0 = 1'b0;
    logic       i_select_strap_bit1 = 1'b0;
    logic       i_select_strap_bit2 = 1'b0;
    wire        i_scl;
    wire        o_sda;
    wire        o_sda_oe;
    wire        o_program_busy;
    wire        sda_m;
    wire        i_sda = (o_sda_oe ? o_sda : 1'b1) & sda_m;
    wire  [6:0] dev = {4'hA, i_select_strap_bit2, i_select_strap_bit1, i_select_strap_bit0};
    int         fails = 0;
    int         tests_run = 0;
    logic [7:0] mdl [0:8191];
    logic [7:0] rd;
    logic       ack;

    eew_slave_write_path #(.PROG_CYCLES(40)) i_dut (.i_clk_sys, .i_reset_n, .i_scl, .i_sda,
        .o_sda, .o_sda_oe, .i_select_strap_bit0, .i_select_strap_bit1, .i_select_strap_bit2,
        .i_write_protect, .o_program_busy);
    eew_bus_master i_mst (.i_sda(i_sda), .o_scl(i_scl), .o_sda(sda_m));

    always #20 i_clk_sys = ~i_clk_sys;

    // Compare one value and report a mismatch at once.
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    // Upper quarter is refused only while the protect pin is high.
    function automatic logic guarded(input logic [12:0] a, input logic w);
        return w && a >= 13'h1800;
    endfunction

    // Start a frame and send a slave address.
    task automatic sel(input logic [7:0] sa, input logic exp);
        @(posedge i_clk_sys);
        #7;
        i_mst.bus_start();
        i_mst.send_byte(sa, ack);
        check({7'h00, ack}, {7'h00, exp}, "address ack");
    endtask

    // Select for writing and load both memory address bytes.
    task automatic set_addr(input logic [12:0] a);
        sel({dev, 1'b0}, 1'b1);
        i_mst.send_byte({3'($urandom()), a[12:8]}, ack);
        check({7'h00, ack}, 8'h01, "high address ack");
        i_mst.send_byte(a[7:0], ack);
        check({7'h00, ack}, 8'h01, "low address ack");
    endtask

    // Completion poll with a write selection.
    task automatic poll(input logic exp);
        sel({dev, 1'b0}, exp);
        i_mst.bus_stop();
    endtask

    // Write n random bytes, then unless the address is protected poll once, wait for busy to drop and poll again.
    task automatic write_blk(input logic [12:0] a, input int n);
        logic [7:0] d;
        logic       p;
        p = guarded(a, i_write_protect);
        set_addr(a);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom());
            i_mst.send_byte(d, ack);
            check({7'h00, ack}, {7'h00, ~p}, "data ack");
            if (!p)
                mdl[{a[12:5], 5'(a[4:0] + i)}] = d;
        end
        i_mst.bus_stop();
        check({7'h00, o_program_busy}, {7'h00, ~p}, "program start");
        if (!p)
        begin
            poll(1'b0);
            for (int k = 0; k < 300 && o_program_busy !== 1'b0; k++)
                @(posedge i_clk_sys);
            poll(1'b1);
        end
    endtask

    // Random read of n bytes from address a.
    task automatic read_blk(input logic [12:0] a, input int n);
        set_addr(a);
        sel({dev, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            i_mst.recv_byte(i < n - 1, rd);
            check(rd, mdl[13'(a + i)], "read data");
        end
        i_mst.bus_stop();
    endtask

    // Print counts and the verdict, then end the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence: bad selections, byte, page and protected writes.
    initial
    begin
        logic [12:0] a;
        int          n;
        void'($urandom(32'h8FB2DBB5));
        {i_select_strap_bit2, i_select_strap_bit1} = 2'($urandom());
        repeat (2) @(posedge i_clk_sys);
        #7 i_reset_n = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        for (int i = 0; i < 4; i++)
        begin
            sel(i == 0 ? {4'h5, dev[2:0], 1'b0} : {4'hA, dev[2:0] ^ 3'(1 << (i - 1)), 1'b0}, 1'b0);
            i_mst.bus_stop();
        end
        a = 13'($urandom_range(6143));
        write_blk(a, 1);
        read_blk(a, 1);
        a = {8'($urandom_range(191)), 5'h1E};
        write_blk(a, 34);
        read_blk({a[12:5], 5'h00}, 32);
        for (int j = 0; j < 3; j++)
        begin
            a = 13'($urandom_range(6143));
            n = 1 + int'($urandom_range(31 - a[4:0]));
            write_blk(a, n);
            read_blk(a, n);
        end
        @(posedge i_clk_sys);
        #7 i_write_protect = 1'b1;
        write_blk(13'h1800 | 13'($urandom_range(2047)), 1);
        write_blk(13'h1FFF, 1);
        write_blk(13'h17FF, 1);
        read_blk(13'h17FF, 1);
        @(posedge i_clk_sys);
        #7 i_write_protect = 1'b0;
        write_blk(13'h1FFF, 1);
        read_blk(13'h1FFF, 1);
        complete_run();
    end

    // Watchdog: the whole sequence needs well under two milliseconds.
    initial
    begin
        #2_000_000;
        fails++;
        complete_run();
    end
endmodule
